/* File: verilog/comparator_control_logic.sv */
// comparator control logic: sync, edge flag, irq, input routing, apb registers
//
// Summary of operation
// [RL1] comparator result is two-flop synchronised, 1-2 cycle latency, then readable
// [RL2] edge field: 00 toggle, 10 falling, 11 rising, 01 reserved no event
// [RL3] event flag set by hardware on the selected synchronised edge
// [RL4] interrupt requested only with flag, enable bit and global enable; irq_o uses flag and irq_en_mask only
// [RL5] flag cleared when the processor executes the comparator vector
// [RL6] writing one to flag bit clears it, zero leaves it
// [RL7] power-off bit switches comparator power off, writable any time
// [RL8] software drops irq enable before changing the power-off bit
// [RL9] software drops irq enable before changing the edge field
// [RL10] bandgap select routes reference to positive input, else positive pin
// [RL11] capture route bit feeds comparator output to timer capture trigger
// [RL12] routed output goes through the capture noise canceller and edge select
// [RL13] mux enable and converter off: channel field picks negative input
// [RL14] software clears converter power reduction before using the input mux
// [RL15] buffer-off bits disable pin input buffers and force port bits zero
// [RL16] converter enable bit gates use of the converter mux by comparator
// [RL17] edges compare synchronised output with previous clock value
`timescale 1ns/1ps
module comparator_control_logic
  import cmp_ctrl_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // analog core
  input wire logic cmp_raw_i,
  output logic cmp_power_off_o,
  output logic bandgap_select_o,
  output logic neg_use_mux_o,
  output logic [2:0] neg_channel_o,
  // cpu interrupt
  input wire logic global_irq_enable_i,
  input wire logic vector_ack_i,
  output logic cmp_irq_o,
  output logic irq_o,
  // timer capture
  output logic capture_trigger_o,
  output logic capture_select_o,
  // pin digital buffers
  input wire logic pos_pin_digital_i,
  input wire logic neg_pin_digital_i,
  output logic pos_pin_port_o,
  output logic neg_pin_port_o,
  output logic pos_buf_enable_o,
  output logic neg_buf_enable_o
);

  // ****************************************
  // state
  // ****************************************
  logic sync_a, sync_b, sync_prev;
  logic [7:0] ctrl, aux;
  logic flag;
  logic irq_en_mask;
  logic next_sync_a, next_sync_b, next_sync_prev;
  logic [7:0] next_ctrl, next_aux;
  logic next_flag, next_irq_en_mask;
  logic [31:0] next_prdata;

  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      EDGE_TOGGLE: hit = cur ^ prev;
      EDGE_FALL: hit = prev & ~cur;
      EDGE_RISE: hit = cur & ~prev;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  logic wr_en, rd_en, mapped;
  logic event_hit;
  logic clr_sw;

  assign wr_en = psel_i & penable_i & pwrite_i;
  // read data is registered in the setup cycle, so it already stands
  // at the edge where the master samples pready in the access phase
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign mapped = (paddr_i == ADDR_CTRL_STATUS) || (paddr_i == ADDR_AUX_CTRL) ||
                  (paddr_i == ADDR_IRQ_STATUS) || (paddr_i == ADDR_IRQ_ENABLE) ||
                  (paddr_i == ADDR_IRQ_CLEAR);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    // [RL1] two-flop synchroniser
    next_sync_a = cmp_raw_i;
    next_sync_b = sync_a;
    // [RL17] previous synchronised value
    next_sync_prev = sync_b;
    // [RL2] edge select decode
    event_hit = edge_hit(ctrl[BIT_EDGE_HI:BIT_EDGE_LO], sync_b, sync_prev);
    clr_sw = 1'b0;
    next_ctrl = ctrl;
    next_aux = aux;
    next_irq_en_mask = irq_en_mask;
    if (wr_en && paddr_i == ADDR_CTRL_STATUS) begin
      // [RL7] power-off and other control bits writable any time
      next_ctrl = pwdata_i[7:0];
      // [RL6] write one to flag position clears
      clr_sw = pwdata_i[BIT_EVENT_FLAG];
    end
    if (wr_en && paddr_i == ADDR_AUX_CTRL) begin
      next_aux = pwdata_i[7:0];
    end
    if (wr_en && paddr_i == ADDR_IRQ_ENABLE) begin
      next_irq_en_mask = pwdata_i[0];
    end
    if (wr_en && paddr_i == ADDR_IRQ_CLEAR) begin
      clr_sw = clr_sw | pwdata_i[0];
    end
    next_ctrl[BIT_SYNC_OUT] = 1'b0;
    next_ctrl[BIT_EVENT_FLAG] = 1'b0;
    next_aux[5] = 1'b0;
    // [RL3] hardware set wins over [RL5] vector clear and software clear
    if (event_hit) begin
      next_flag = 1'b1;
    end else if (clr_sw || vector_ack_i) begin
      next_flag = 1'b0;
    end else begin
      next_flag = flag;
    end
    next_prdata = 32'h0000_0000;
    if (rd_en) begin
      unique case (paddr_i)
        ADDR_CTRL_STATUS: begin
          next_prdata[7:0] = ctrl;
          next_prdata[BIT_SYNC_OUT] = sync_b;
          next_prdata[BIT_EVENT_FLAG] = flag;
        end
        ADDR_AUX_CTRL: next_prdata[7:0] = aux;
        ADDR_IRQ_STATUS: next_prdata[0] = flag;
        ADDR_IRQ_ENABLE: next_prdata[0] = irq_en_mask;
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_prev <= 1'b0;
      ctrl <= CTRL_RESET;
      aux <= AUX_RESET;
      flag <= 1'b0;
      irq_en_mask <= 1'b0;
      prdata_o <= 32'h0000_0000;
    end else begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_prev <= next_sync_prev;
      ctrl <= next_ctrl;
      aux <= next_aux;
      flag <= next_flag;
      irq_en_mask <= next_irq_en_mask;
      prdata_o <= next_prdata;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // [RL4] cmp_irq_o gated by flag, enable bit and global enable; irq_o by flag and irq_en_mask only
  assign cmp_irq_o = flag & ctrl[BIT_IRQ_EN] & global_irq_enable_i;
  assign irq_o = flag & irq_en_mask;
  // [RL7] power control to analog core
  assign cmp_power_off_o = ctrl[BIT_POWER_OFF];
  // [RL10] positive input source
  assign bandgap_select_o = ctrl[BIT_BANDGAP];
  // [RL13] negative mux only while converter is off
  // [RL16] converter enable gates mux use
  assign neg_use_mux_o = aux[BIT_MUX_EN] & ~aux[BIT_CONV_EN];
  assign neg_channel_o = neg_use_mux_o ? aux[BIT_CHAN_LSB +: CHAN_W] : 3'h0;
  // [RL11] capture routing, [RL12] timer front end filters it like a pin
  assign capture_select_o = ctrl[BIT_CAPTURE];
  assign capture_trigger_o = ctrl[BIT_CAPTURE] & sync_b;
  // [RL15] buffer disable forces port reads low
  assign pos_buf_enable_o = ~aux[BIT_POS_BUF_OFF];
  assign neg_buf_enable_o = ~aux[BIT_NEG_BUF_OFF];
  assign pos_pin_port_o = pos_pin_digital_i & ~aux[BIT_POS_BUF_OFF];
  assign neg_pin_port_o = neg_pin_digital_i & ~aux[BIT_NEG_BUF_OFF];

  // ****************************************
  // checks
  // ****************************************
  sequence s_rise;
    !sync_prev ##1 sync_prev;
  endsequence

  chk_sync_latency: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL1]
    sync_b == $past(cmp_raw_i, 2)) else $error("sync stage did not follow");
  chk_rise_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL3]
    (ctrl[1:0] == EDGE_RISE && sync_b && !sync_prev) |=> flag) else $error("rise missed");
  chk_fall_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL2]
    (ctrl[1:0] == EDGE_FALL && !sync_b && sync_prev) |=> flag) else $error("fall missed");
  chk_rsvd_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL2]
    (ctrl[1:0] == EDGE_RSVD && !flag && !wr_en) |=> !flag) else $error("reserved mode set flag");
  chk_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL4]
    cmp_irq_o == (flag && ctrl[BIT_IRQ_EN] && global_irq_enable_i)) else $error("irq gating wrong");
  chk_vector_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL5]
    (vector_ack_i && !event_hit) |=> !flag) else $error("vector did not clear flag");
  chk_sw_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL6]
    (wr_en && paddr_i == ADDR_CTRL_STATUS && !pwdata_i[4] && flag && !vector_ack_i) |=> flag)
    else $error("zero write cleared flag");
  chk_mux_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL13]
    aux[BIT_CONV_EN] |-> !neg_use_mux_o) else $error("mux used while converter on");
  chk_capture_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL11]
    !ctrl[BIT_CAPTURE] |-> !capture_trigger_o) else $error("capture driven while off");
  chk_buf_force: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL15]
    aux[BIT_POS_BUF_OFF] |-> !pos_pin_port_o) else $error("port bit not forced low");
  chk_prev_edge: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL17]
    s_rise |-> ($past(sync_b) && !$past(sync_b, 2))) else $error("previous value tracking wrong");

  // the falling counterpart of the edge tracker
  sequence s_fall;
    sync_prev ##1 !sync_prev;
  endsequence

  // event in one cycle, vector taken the next with no new event
  sequence s_event_then_ack;
    event_hit ##1 (vector_ack_i && !event_hit);
  endsequence

  // event, then the flag one clock later
  sequence s_flag_raised;
    event_hit ##1 flag;
  endsequence

  chk_fall_prev: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL17]
    s_fall |-> (!$past(sync_b) && $past(sync_b, 2))) else $error("falling value tracking wrong");
  chk_ack_after_event: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL5]
    s_event_then_ack |=> !flag) else $error("vector after event left flag set");
  chk_irq_follows: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL4]
    (s_flag_raised ##0 (ctrl[BIT_IRQ_EN] && global_irq_enable_i)) |-> cmp_irq_o)
    else $error("enabled flag raised no request");
  // toggle mode reacts to either direction of the synchronised output
  chk_toggle_sets: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL2]
    (ctrl[1:0] == EDGE_TOGGLE && sync_b != sync_prev) |=> flag) else $error("toggle missed");
  // with no step on the synchronised output the flag cannot rise by itself
  chk_no_spurious: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL3]
    (!flag && sync_b == sync_prev) |=> !flag) else $error("flag rose without an event");
  chk_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL3]
    (flag && !clr_sw && !vector_ack_i) |=> flag) else $error("flag dropped without a clear");
  chk_w1c_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL6]
    (wr_en && paddr_i == ADDR_CTRL_STATUS && pwdata_i[BIT_EVENT_FLAG] && !event_hit) |=> !flag)
    else $error("one write left flag set");
  chk_clear_reg: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL6]
    (wr_en && paddr_i == ADDR_IRQ_CLEAR && pwdata_i[0] && !event_hit) |=> !flag)
    else $error("clear register left flag set");
  chk_irq_needs_en: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL4]
    (!ctrl[BIT_IRQ_EN] || !global_irq_enable_i) |-> !cmp_irq_o) else $error("irq without enables");
  chk_irq_mask: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !irq_en_mask |-> !irq_o) else $error("masked interrupt line raised");

  // ****************************************
  // checks: routing and bus
  // ****************************************
  chk_power_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL7]
    (wr_en && paddr_i == ADDR_CTRL_STATUS) |=> (cmp_power_off_o == $past(pwdata_i[BIT_POWER_OFF])))
    else $error("power-off bit not applied");
  chk_bandgap_route: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL10]
    (wr_en && paddr_i == ADDR_CTRL_STATUS) |=> (bandgap_select_o == $past(pwdata_i[BIT_BANDGAP])))
    else $error("bandgap select not applied");
  chk_capture_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL12]
    capture_select_o |-> (capture_trigger_o == sync_b))
    else $error("capture path not following output");
  chk_mux_channel: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL13]
    (aux[BIT_MUX_EN] && !aux[BIT_CONV_EN]) |->
    (neg_use_mux_o && neg_channel_o == aux[BIT_CHAN_LSB +: CHAN_W])) else $error("negative mux channel wrong");
  chk_mux_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL13]
    !aux[BIT_MUX_EN] |-> (!neg_use_mux_o && neg_channel_o == 3'h0))
    else $error("negative mux used while disabled");
  chk_neg_buf_force: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL15]
    aux[BIT_NEG_BUF_OFF] |-> (!neg_pin_port_o && !neg_buf_enable_o))
    else $error("negative port bit not forced low");
  chk_pos_buf_off: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL15]
    aux[BIT_POS_BUF_OFF] |-> !pos_buf_enable_o) else $error("positive buffer left on");
  chk_read_sync: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL1]
    (rd_en && paddr_i == ADDR_CTRL_STATUS) |=> (prdata_o[BIT_SYNC_OUT] == $past(sync_b)))
    else $error("read sync bit wrong");
  chk_read_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [RL3]
    (rd_en && paddr_i == ADDR_IRQ_STATUS) |=> (prdata_o[0] == $past(flag))) else $error("read flag wrong");
  // an unmapped write must leave every stored control bit alone
  chk_unmapped_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wr_en && !mapped) |=> (ctrl == $past(ctrl) && aux == $past(aux)))
    else $error("unmapped write changed a register");

endmodule

/* File: verilog/cmp_ctrl_pkg.sv */
// constants for the comparator control block
package cmp_ctrl_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL_STATUS = 12'h000;
  localparam logic [11:0] ADDR_AUX_CTRL = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h010;
  // control/status bit positions
  localparam int BIT_POWER_OFF = 7;
  localparam int BIT_BANDGAP = 6;
  localparam int BIT_SYNC_OUT = 5;
  localparam int BIT_EVENT_FLAG = 4;
  localparam int BIT_IRQ_EN = 3;
  localparam int BIT_CAPTURE = 2;
  localparam int BIT_EDGE_HI = 1;
  localparam int BIT_EDGE_LO = 0;
  // aux control bit positions
  localparam int BIT_CONV_EN = 7;
  localparam int BIT_MUX_EN = 6;
  localparam int BIT_NEG_BUF_OFF = 4;
  localparam int BIT_POS_BUF_OFF = 3;
  localparam int BIT_CHAN_LSB = 0;
  localparam int CHAN_W = 3;
  // reset values and edge select codes
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] AUX_RESET = 8'h00;
  localparam logic [1:0] EDGE_TOGGLE = 2'h0;
  localparam logic [1:0] EDGE_RSVD = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_RISE = 2'h3;
endpackage

/* File: verif/cmp_core_model.sv */
// behavioural analog comparator core driving the raw result
`timescale 1ns/1ps
module cmp_core_model (
  // control
  input wire logic core_clk_i,
  input wire logic level_i,
  input wire logic power_off_i,
  // result
  output logic cmp_raw_o
);
  // unpowered core
  // an unpowered core gives no clean level, so it wobbles every cycle
  always_ff @(posedge core_clk_i) begin
    cmp_raw_o <= power_off_i ? ~cmp_raw_o : level_i;
  end
endmodule

/* File: verif/comparator_control_logic_bench.sv */
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module comparator_control_logic_bench;
  import cmp_ctrl_pkg::*;
  logic core_clk_i, rst_n_i, psel_i, penable_i, pwrite_i, cmp_raw_i, level;
  logic global_irq_enable_i, vector_ack_i, pos_pin_digital_i, neg_pin_digital_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic pready_o, pslverr_o, cmp_power_off_o, bandgap_select_o, neg_use_mux_o, cmp_irq_o, irq_o;
  logic capture_trigger_o, capture_select_o, pos_pin_port_o, neg_pin_port_o, pos_buf_enable_o, neg_buf_enable_o;
  logic [2:0] neg_channel_o;
  int bad_count, check_count, seed;
  comparator_control_logic comparator_control_logic_inst (.core_clk_i, .rst_n_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .cmp_raw_i, .cmp_power_off_o,
    .bandgap_select_o, .neg_use_mux_o, .neg_channel_o, .global_irq_enable_i, .vector_ack_i, .cmp_irq_o,
    .irq_o, .capture_trigger_o, .capture_select_o, .pos_pin_digital_i, .neg_pin_digital_i, .pos_pin_port_o,
    .neg_pin_port_o, .pos_buf_enable_o, .neg_buf_enable_o);
  cmp_core_model cmp_core_model_inst (.core_clk_i, .level_i(level), .power_off_i(cmp_power_off_o),
    .cmp_raw_o(cmp_raw_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // ****************************************
  // bus tasks and expectations
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  task automatic check(input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // read data and error are taken at the edge that samples pready high
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] r,
                     output logic err);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready_o !== 1'b1);
    err = pslverr_o;
    r = prdata_o[7:0];
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    check(x, r);
  endtask
  function automatic logic [7:0] exp_flag(input logic [1:0] m, input logic rise);
    return 8'((m == EDGE_TOGGLE) || (m == (rise ? EDGE_RISE : EDGE_FALL)));
  endfunction
  function automatic logic [7:0] exp_neg(input logic [7:0] a);
    logic mx;
    mx = a[6] & ~a[7];
    return {4'h0, mx, mx ? a[2:0] : 3'h0};
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    cyc(5000);
    bad_count++;
    wrap_up();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] v, a, p;
    logic e;
    {rst_n_i, psel_i, penable_i, pwrite_i, level, vector_ack_i, global_irq_enable_i} = '0;
    {pos_pin_digital_i, neg_pin_digital_i, paddr_i, pwdata_i} = '0;
    seed = 32'hBA76629E;
    cyc(6);
    rst_n_i <= 1'b1;
    rd(ADDR_CTRL_STATUS, CTRL_RESET);
    rd(ADDR_AUX_CTRL, AUX_RESET);
    check(8'h03, 8'({pos_buf_enable_o, neg_buf_enable_o}));
    apb(1'b0, 12'h020, 8'h00, v, e);
    check(8'h01, 8'(e));
    check(8'h00, v);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL_STATUS, {6'h04, 2'(i)});
      for (int k = 1; k >= 0; k--) begin
        cyc(1);
        level <= k[0];
        cyc(6);
        rd(ADDR_IRQ_STATUS, exp_flag(2'(i), k[0]));
        wr(ADDR_IRQ_CLEAR, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h00);
      end
    end
    wr(ADDR_CTRL_STATUS, 8'h08);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    cyc(1);
    global_irq_enable_i <= 1'b1;
    level <= 1'b1;
    cyc(6);
    #1;
    check(8'h03, 8'({cmp_irq_o, irq_o}));
    cyc(1);
    global_irq_enable_i <= 1'b0;
    cyc(1);
    #1;
    check(8'h01, 8'({cmp_irq_o, irq_o}));
    cyc(1);
    global_irq_enable_i <= 1'b1;
    vector_ack_i <= 1'b1;
    cyc(1);
    vector_ack_i <= 1'b0;
    cyc(1);
    #1;
    check(8'h00, 8'({cmp_irq_o, irq_o}));
    cyc(1);
    level <= 1'b0;
    cyc(6);
    wr(ADDR_CTRL_STATUS, 8'h08);
    rd(ADDR_IRQ_STATUS, 8'h01);
    wr(ADDR_CTRL_STATUS, 8'h18);
    rd(ADDR_IRQ_STATUS, 8'h00);
    wr(ADDR_CTRL_STATUS, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($random(seed)) & 8'hC4;
      a = (i == 0) ? 8'h47 : 8'($random(seed)) & 8'hDF;
      p = 8'($random(seed));
      cyc(1);
      pos_pin_digital_i <= p[0];
      neg_pin_digital_i <= p[1];
      wr(ADDR_CTRL_STATUS, v);
      wr(ADDR_AUX_CTRL, a);
      #1;
      check(8'({v[7], v[6], v[2]}),
            8'({cmp_power_off_o, bandgap_select_o, capture_select_o}));
      check(exp_neg(a), 8'({neg_use_mux_o, neg_channel_o}));
      check(8'({~a[3], ~a[4], p[0] & ~a[3], p[1] & ~a[4]}),
            8'({pos_buf_enable_o, neg_buf_enable_o, pos_pin_port_o, neg_pin_port_o}));
    end
    wr(ADDR_CTRL_STATUS, 8'h00);
    cyc(1);
    level <= 1'b1;
    cyc(6);
    wr(ADDR_CTRL_STATUS, 8'h14);
    rd(ADDR_CTRL_STATUS, 8'h24);
    check(8'h01, 8'(capture_trigger_o));
    cyc(1);
    level <= 1'b0;
    cyc(6);
    #1;
    check(8'h00, 8'(capture_trigger_o));
    wrap_up();
  end
endmodule
